// ### agcgs_pkg.sv
package agcgs_pkg;
  // ---------------------------------------------------------
  // register port
  // ---------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_FIXED = 4'h1;
  localparam logic [3:0] OFF_MAXG = 4'h2;
  localparam logic [3:0] OFF_LIMIT = 4'h3;
  localparam logic [3:0] OFF_NGATE = 4'h4;
  localparam logic [3:0] OFF_ATTACK = 4'h5;
  localparam logic [3:0] OFF_RELEASE = 4'h6;
  localparam logic [3:0] OFF_HOLD = 4'h7;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  // ---------------------------------------------------------
  // control and status fields
  // ---------------------------------------------------------
  localparam int CTRL_AGC_EN = 0;
  localparam int CTRL_LIM_EN = 1;
  localparam int CTRL_HOLD_EN = 2;
  localparam int CTRL_SD_LEFT = 3;
  localparam int CTRL_SD_RIGHT = 4;
  localparam int CTRL_RATIO_LO = 5;
  localparam int STAT_GATED = 8;
  localparam int STAT_AFTER_DEC = 9;
  localparam int STAT_TRACK = 10;
  // ---------------------------------------------------------
  // reset values
  // ---------------------------------------------------------
  localparam logic [6:0] RST_CTRL = 7'h07;
  localparam logic [5:0] RST_FIXED = 6'h06;
  localparam logic [4:0] RST_MAXG = 5'h1e;
  localparam logic [7:0] RST_LIMIT = 8'h00;
  localparam logic [7:0] RST_NGATE = 8'hc4;
  localparam logic [15:0] RST_ATTACK = 16'h0064;
  localparam logic [15:0] RST_RELEASE = 16'h2710;
  localparam logic [15:0] RST_HOLD = 16'h4e20;
  // ---------------------------------------------------------
  // gain law, in dB and half-dB codes
  // ---------------------------------------------------------
  localparam logic signed [10:0] ROT_DB = 11'sh00a;
  localparam logic signed [10:0] FIX_MIN_CMP = -11'sh01c;
  localparam logic signed [10:0] FIX_MIN_NOCMP = 11'sh000;
  localparam logic signed [10:0] FIX_MAX = 11'sh01e;
  localparam logic signed [10:0] GAIN_MIN_CODE = -11'sh038;
  localparam logic signed [10:0] GAIN_MAX_CODE = 11'sh03c;
  localparam logic signed [10:0] GAIN_STEP = 11'sh001;
  // ---------------------------------------------------------
  // timing: interval registers count ticks
  // ---------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_STAGES = 3;
  typedef enum logic [0:0] {M_FIXED, M_TRACK} agcgs_mode_e;
endpackage

// ### agcgs_sync.sv
`timescale 1ns/1ps
module agcgs_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // raw and settled value
  input wire logic [W-1:0] raw,
  output logic [W-1:0] settled
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a change once the last two stages agree
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      out_q <= '0;
    else if (s2_q == s3_q)
      out_q <= s3_q;
  end

  assign settled = out_q;
endmodule // agcgs_sync

// ### agcgs_timer.sv
`timescale 1ns/1ps
module agcgs_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // tick and control
  input wire logic tick,
  input wire logic restart,
  input wire logic [15:0] limit,
  // interval over
  output logic done
);
  logic [15:0] count_q;

  // saturating tick counter, starts expired so nothing is pending
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      count_q <= 16'hffff;
    else if (restart)
      count_q <= 16'h0000;
    else if (tick && count_q != 16'hffff)
      count_q <= count_q + 16'h0001;
  end

  assign done = (count_q >= limit);
endmodule // agcgs_timer

// ### agcgs_top.sv
`timescale 1ns/1ps
module agcgs_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // envelope detector, dBV signed
  input wire logic [7:0] env_level,
  // amplifier stage
  output logic [7:0] gain_code,
  output logic gain_dec_pulse,
  output logic gain_inc_pulse,
  output logic left_on,
  output logic right_on
);
  // ---------------------------------------------------------
  // registers
  // ---------------------------------------------------------
  logic [6:0] ctrl_q;
  logic [5:0] fixed_q;
  logic [4:0] maxg_q;
  logic [7:0] limit_q;
  logic [7:0] ngate_q;
  logic [15:0] attack_q;
  logic [15:0] release_q;
  logic [15:0] hold_q;
  logic [15:0] rdata_q;
  logic signed [10:0] gain_q;
  logic signed [10:0] gain_d;
  logic dec_q;
  logic inc_q;
  logic left_on_q;
  logic right_on_q;
  logic after_dec_q;
  logic [6:0] tick_cnt_q;
  logic tick_q;
  agcgs_pkg::agcgs_mode_e mode_q;
  agcgs_pkg::agcgs_mode_e mode_d;
  logic gated;
  logic agc_en;
  logic lim_en;
  logic hold_en;
  logic sd_left;
  logic sd_right;
  logic [1:0] ratio;
  assign agc_en = ctrl_q[agcgs_pkg::CTRL_AGC_EN];
  assign lim_en = ctrl_q[agcgs_pkg::CTRL_LIM_EN];
  assign hold_en = ctrl_q[agcgs_pkg::CTRL_HOLD_EN];
  assign sd_left = ctrl_q[agcgs_pkg::CTRL_SD_LEFT];
  assign sd_right = ctrl_q[agcgs_pkg::CTRL_SD_RIGHT];
  assign ratio = ctrl_q[agcgs_pkg::CTRL_RATIO_LO +: 2];

  // ---------------------------------------------------------
  // register writes
  // ---------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q <= agcgs_pkg::RST_CTRL;
      fixed_q <= agcgs_pkg::RST_FIXED;
      maxg_q <= agcgs_pkg::RST_MAXG;
      limit_q <= agcgs_pkg::RST_LIMIT;
      ngate_q <= agcgs_pkg::RST_NGATE;
      attack_q <= agcgs_pkg::RST_ATTACK;
      release_q <= agcgs_pkg::RST_RELEASE;
      hold_q <= agcgs_pkg::RST_HOLD;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        agcgs_pkg::OFF_CTRL: ctrl_q <= reg_wdata[6:0];
        agcgs_pkg::OFF_FIXED: fixed_q <= reg_wdata[5:0];
        agcgs_pkg::OFF_MAXG: maxg_q <= reg_wdata[4:0];
        agcgs_pkg::OFF_LIMIT: limit_q <= reg_wdata[7:0];
        agcgs_pkg::OFF_NGATE: ngate_q <= reg_wdata[7:0];
        agcgs_pkg::OFF_ATTACK: attack_q <= reg_wdata;
        agcgs_pkg::OFF_RELEASE: release_q <= reg_wdata;
        agcgs_pkg::OFF_HOLD: hold_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------
  // register reads, data valid for one cycle only
  // ---------------------------------------------------------
  logic [15:0] status_word;
  assign status_word = {5'h00, (mode_q == agcgs_pkg::M_TRACK), after_dec_q, gated, gain_q[7:0]};
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_q <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        agcgs_pkg::OFF_CTRL: rdata_q <= {9'h000, ctrl_q};
        agcgs_pkg::OFF_FIXED: rdata_q <= {10'h000, fixed_q};
        agcgs_pkg::OFF_MAXG: rdata_q <= {11'h000, maxg_q};
        agcgs_pkg::OFF_LIMIT: rdata_q <= {8'h00, limit_q};
        agcgs_pkg::OFF_NGATE: rdata_q <= {8'h00, ngate_q};
        agcgs_pkg::OFF_ATTACK: rdata_q <= attack_q;
        agcgs_pkg::OFF_RELEASE: rdata_q <= release_q;
        agcgs_pkg::OFF_HOLD: rdata_q <= hold_q;
        agcgs_pkg::OFF_STATUS: rdata_q <= status_word;
        default: rdata_q <= 16'h0000;
      endcase
    end
    else
      rdata_q <= 16'h0000;
  end

  // ---------------------------------------------------------
  // envelope input
  // ---------------------------------------------------------
  logic [7:0] env_sync;
  logic signed [10:0] env_db;
  agcgs_sync #(
    .W(8)
  ) u_env_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .raw(env_level),
    .settled(env_sync)
  );
  // gain decisions use the detector envelope only
  assign env_db = 11'(signed'(env_sync));

  // ---------------------------------------------------------
  // tick divider for the interval timers
  // ---------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt_q <= 7'h00;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == 7'(agcgs_pkg::TICK_CYC - 1))
    begin
      tick_cnt_q <= 7'h00;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 7'h01;
      tick_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------
  // fixed gain range and target gain
  // ---------------------------------------------------------
  logic signed [10:0] fix_db;
  logic signed [10:0] fix_lo;
  logic signed [10:0] fix_clamped;
  logic signed [10:0] fix_code;
  logic signed [10:0] diff_half;
  logic signed [10:0] comp_half;
  logic signed [10:0] lim_code;
  logic signed [10:0] max_code;
  logic signed [10:0] target;

  assign fix_db = 11'(signed'(fixed_q));
  assign fix_lo = (ratio != 2'b00) ? agcgs_pkg::FIX_MIN_CMP : agcgs_pkg::FIX_MIN_NOCMP;
  assign fix_code = fix_clamped <<< 1;
  assign diff_half = (agcgs_pkg::ROT_DB - env_db) <<< 1;
  assign lim_code = ((11'(signed'(limit_q))) - env_db) <<< 1;
  assign max_code = 11'({1'b0, maxg_q}) <<< 1;

  always_comb
  begin
    if (fix_db < fix_lo)
      fix_clamped = fix_lo;
    else if (fix_db > agcgs_pkg::FIX_MAX)
      fix_clamped = agcgs_pkg::FIX_MAX;
    else
      fix_clamped = fix_db;
  end

  always_comb
  begin
    if (ratio == 2'b00)
      comp_half = 11'sh000;
    else
      comp_half = diff_half - (diff_half >>> ratio);
    target = fix_code + comp_half;
    if (target > max_code)
      target = max_code;
    if (lim_en && target > lim_code)
      target = lim_code;
    if (target > agcgs_pkg::GAIN_MAX_CODE)
      target = agcgs_pkg::GAIN_MAX_CODE;
    if (target < agcgs_pkg::GAIN_MIN_CODE)
      target = agcgs_pkg::GAIN_MIN_CODE;
  end

  // ---------------------------------------------------------
  // interval timers
  // ---------------------------------------------------------
  logic attack_done;
  logic release_done;
  logic hold_done;
  logic restart;
  agcgs_timer u_attack (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(tick_q),
    .restart(restart),
    .limit(attack_q),
    .done(attack_done)
  );
  agcgs_timer u_release (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(tick_q),
    .restart(restart),
    .limit(release_q),
    .done(release_done)
  );
  agcgs_timer u_hold (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(tick_q),
    .restart(restart),
    .limit(hold_q),
    .done(hold_done)
  );

  // ---------------------------------------------------------
  // step decisions
  // ---------------------------------------------------------
  logic need_dn;
  logic need_up;
  logic up_wait_ok;
  logic step_dn;
  logic step_up;
  logic wake;
  logic sd_left_q;
  logic sd_right_q;
  assign gated = (env_db < 11'(signed'(ngate_q)));
  // no step while the target sits on the current gain
  assign need_dn = (gain_q > target);
  assign need_up = (gain_q < target);
  // with hold enabled, the first rise after a drop waits for hold as well as release
  assign up_wait_ok = release_done && (!(hold_en && after_dec_q) || hold_done);
  // drop at once when attack is idle, otherwise wait for it
  assign step_dn = (mode_q == agcgs_pkg::M_TRACK) && !gated && need_dn && attack_done
                   && (gain_q > agcgs_pkg::GAIN_MIN_CODE);
  assign step_up = (mode_q == agcgs_pkg::M_TRACK) && !gated && need_up && up_wait_ok
                   && (gain_q < agcgs_pkg::GAIN_MAX_CODE);
  assign wake = (sd_left_q && !sd_left) || (sd_right_q && !sd_right);
  // every gain step, mode change and wake restarts all three intervals
  assign restart = step_dn || step_up || (mode_q != mode_d) || wake;

  // ---------------------------------------------------------
  // mode
  // ---------------------------------------------------------
  always_comb
  begin
    case (mode_q)
      agcgs_pkg::M_FIXED:
      begin
        if (agc_en && !(sd_left && sd_right))
          mode_d = agcgs_pkg::M_TRACK;
        else
          mode_d = agcgs_pkg::M_FIXED;
      end
      agcgs_pkg::M_TRACK:
      begin
        if (!agc_en || (sd_left && sd_right))
          mode_d = agcgs_pkg::M_FIXED;
        else
          mode_d = agcgs_pkg::M_TRACK;
      end
      default: mode_d = agcgs_pkg::M_FIXED;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      mode_q <= agcgs_pkg::M_FIXED;
    else
      mode_q <= mode_d;
  end

  // ---------------------------------------------------------
  // gain code
  // ---------------------------------------------------------
  always_comb
  begin
    if (mode_q != agcgs_pkg::M_TRACK || wake)
      gain_d = fix_code;
    else if (step_dn)
      gain_d = gain_q - agcgs_pkg::GAIN_STEP;
    else if (step_up)
      gain_d = gain_q + agcgs_pkg::GAIN_STEP;
    else
      gain_d = gain_q;
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      gain_q <= 11'sh000;
    else
      gain_q <= gain_d;
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dec_q <= 1'b0;
      inc_q <= 1'b0;
    end
    else
    begin
      dec_q <= step_dn && !wake;
      inc_q <= step_up && !wake;
    end
  end

  // first rise after a drop uses hold
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      after_dec_q <= 1'b0;
    else if (mode_q != agcgs_pkg::M_TRACK || wake)
      after_dec_q <= 1'b0;
    else if (step_dn)
      after_dec_q <= 1'b1;
    else if (step_up)
      after_dec_q <= 1'b0;
  end

  // ---------------------------------------------------------
  // channel shutdown
  // ---------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sd_left_q <= 1'b0;
      sd_right_q <= 1'b0;
      left_on_q <= 1'b0;
      right_on_q <= 1'b0;
    end
    else
    begin
      sd_left_q <= sd_left;
      sd_right_q <= sd_right;
      left_on_q <= !sd_left;
      right_on_q <= !sd_right;
    end
  end

  assign reg_rdata = rdata_q;
  assign gain_code = gain_q[7:0];
  assign gain_dec_pulse = dec_q;
  assign gain_inc_pulse = inc_q;
  assign left_on = left_on_q;
  assign right_on = right_on_q;
endmodule // agcgs_top

// ### agcgs_chk_monitor.sv
`timescale 1ns/1ps
// ---------------------------------------------------------
// port checker
// ---------------------------------------------------------
module agcgs_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // envelope and amplifier stage
  input wire logic [7:0] env_level,
  input wire logic [7:0] gain_code,
  input wire logic gain_dec_pulse,
  input wire logic gain_inc_pulse,
  input wire logic left_on,
  input wire logic right_on
);
  localparam int TC = agcgs_pkg::TICK_CYC;
  logic [6:0] ctl_q;
  logic [4:0] mg_q;
  logic [15:0] att_q;
  logic [15:0] rel_q;
  logic [15:0] hld_q;
  logic fx_q;
  logic fx2_q;
  logic dec_last_q;
  int gap_q;
  int gate_q;
  // shadow of the programmed values
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_q <= agcgs_pkg::RST_CTRL;
      mg_q <= agcgs_pkg::RST_MAXG;
      att_q <= agcgs_pkg::RST_ATTACK;
      rel_q <= agcgs_pkg::RST_RELEASE;
      hld_q <= agcgs_pkg::RST_HOLD;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        agcgs_pkg::OFF_CTRL: ctl_q <= reg_wdata[6:0];
        agcgs_pkg::OFF_MAXG: mg_q <= reg_wdata[4:0];
        agcgs_pkg::OFF_ATTACK: att_q <= reg_wdata;
        agcgs_pkg::OFF_RELEASE: rel_q <= reg_wdata;
        agcgs_pkg::OFF_HOLD: hld_q <= reg_wdata;
        default: ;
      endcase
    end
  end
  // cycles since the last step, gated run, fixed mode
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gap_q <= 32'h0fffffff;
      gate_q <= 0;
      fx_q <= 1'b0;
      fx2_q <= 1'b0;
      dec_last_q <= 1'b0;
    end
    else
    begin
      gap_q <= (gain_inc_pulse || gain_dec_pulse) ? 1 : gap_q + ((gap_q < 32'h0fffffff) ? 1 : 0);
      gate_q <= ($signed(env_level) < $signed(agcgs_pkg::RST_NGATE)) ? gate_q + 1 : 0;
      fx_q <= !ctl_q[0] || (ctl_q[3] && ctl_q[4]);
      fx2_q <= fx_q;
      dec_last_q <= gain_dec_pulse || (dec_last_q && !gain_inc_pulse);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  dec_step_a: assert property (gain_dec_pulse |-> gain_code == $past(gain_code) - 8'h01)
    else $error("decrement is not one step");
  inc_step_a: assert property (gain_inc_pulse |-> gain_code == $past(gain_code) + 8'h01)
    else $error("increment is not one step");
  attack_gap_a: assert property (gain_dec_pulse |-> gap_q > (int'(att_q) - 1) * TC)
    else $error("decrements too close");
  release_gap_a: assert property (gain_inc_pulse |-> gap_q > (int'(rel_q) - 1) * TC)
    else $error("increments too close");
  hold_gap_a: assert property (gain_inc_pulse && dec_last_q && ctl_q[2] |->
    gap_q > (int'(hld_q) - 1) * TC) else $error("increment before hold ran out");
  max_gain_a: assert property (gain_inc_pulse |->
    $signed(gain_code) <= $signed({2'b00, mg_q, 1'b0})) else $error("gain above maximum");
  gate_hold_a: assert property (gate_q >= 8 |-> !gain_inc_pulse && !gain_dec_pulse)
    else $error("step below noise gate");
  fixed_still_a: assert property (fx_q && fx2_q |-> !gain_inc_pulse && !gain_dec_pulse)
    else $error("step in fixed mode");
  shut_ctl_a: assert property (reg_wr && reg_addr == agcgs_pkg::OFF_CTRL |->
    ##2 (left_on == !ctl_q[3] && right_on == !ctl_q[4])) else $error("channel enable wrong");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
endmodule // agcgs_chk

bind agcgs_top agcgs_chk u_chk (
  .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .env_level(env_level),
  .gain_code(gain_code), .gain_dec_pulse(gain_dec_pulse), .gain_inc_pulse(gain_inc_pulse),
  .left_on(left_on), .right_on(right_on)
);

// ### agcgs_env_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------
// envelope detector model
// ---------------------------------------------------------
module agcgs_env_model (
  // clock
  input wire logic mclk,
  // wanted level
  input wire logic signed [7:0] level_cmd,
  // detected envelope, slews 1 dB a cycle
  output logic [7:0] env_level
);
  initial env_level = 8'hec;
  always @(posedge mclk)
  begin
    if ($signed(env_level) < level_cmd)
      env_level <= env_level + 8'h01;
    else if ($signed(env_level) > level_cmd)
      env_level <= env_level - 8'h01;
  end
endmodule // agcgs_env_model

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int TC = agcgs_pkg::TICK_CYC;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic signed [7:0] level_cmd = 8'hec;
  logic [7:0] env_level;
  logic [7:0] gain_code;
  logic gain_dec_pulse;
  logic gain_inc_pulse;
  logic left_on;
  logic right_on;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  always #4 mclk = ~mclk;
  agcgs_top uut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .env_level(env_level),
    .gain_code(gain_code), .gain_dec_pulse(gain_dec_pulse), .gain_inc_pulse(gain_inc_pulse),
    .left_on(left_on), .right_on(right_on));
  agcgs_env_model u_env (.mclk(mclk), .level_cmd(level_cmd), .env_level(env_level));
  // ---------------------------------------------------------
  // helpers
  // ---------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_g(input logic [7:0] exp);
    chk("gain_code", {8'h00, gain_code}, {8'h00, exp});
  endtask
  task automatic chk_rng(input string what, input int n, input int lo, input int hi);
    chk(what, {15'h0000, n >= lo && n <= hi}, 16'h0001);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask
  task automatic wait_pulse(input bit inc);
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (n < 40000 && (inc ? gain_inc_pulse : gain_dec_pulse) !== 1'b1);
  endtask
  task automatic set_level(input logic [7:0] v);
    @(posedge mclk);
    level_cmd <= v;
  endtask
  // ---------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------
  task automatic t_reset;
    rd(agcgs_pkg::OFF_CTRL, 16'(agcgs_pkg::RST_CTRL), "ctrl");
    rd(agcgs_pkg::OFF_FIXED, 16'(agcgs_pkg::RST_FIXED), "fixed");
    rd(agcgs_pkg::OFF_MAXG, 16'(agcgs_pkg::RST_MAXG), "maxg");
    rd(agcgs_pkg::OFF_LIMIT, 16'(agcgs_pkg::RST_LIMIT), "limit");
    rd(agcgs_pkg::OFF_NGATE, 16'(agcgs_pkg::RST_NGATE), "ngate");
    rd(agcgs_pkg::OFF_ATTACK, agcgs_pkg::RST_ATTACK, "attack");
    rd(agcgs_pkg::OFF_RELEASE, agcgs_pkg::RST_RELEASE, "release");
    rd(agcgs_pkg::OFF_HOLD, agcgs_pkg::RST_HOLD, "hold");
    rd(4'hf, 16'h0000, "unmapped");
    wr(agcgs_pkg::OFF_STATUS, 16'hffff);
    rd(agcgs_pkg::OFF_STATUS, 16'h040c, "status");
    chk("on", {14'h0000, left_on, right_on}, 16'h0003);
  endtask
  task automatic t_track;
    int t0;
    wr(agcgs_pkg::OFF_ATTACK, 16'h0002);
    wr(agcgs_pkg::OFF_RELEASE, 16'h00c8);
    wr(agcgs_pkg::OFF_HOLD, 16'h00f0);
    idle(3 * TC);
    t0 = cyc;
    set_level(8'hfb);
    wait_pulse(1'b0);
    chk_rng("first drop", cyc - t0, 1, 40);
    t0 = cyc;
    wait_pulse(1'b0);
    chk_rng("attack gap", cyc - t0, TC + 1, 2 * TC + 4);
    t0 = cyc;
    idle(600);
    chk_g(8'h0a);
    set_level(8'hec);
    wait_pulse(1'b1);
    chk_rng("hold gap", cyc - t0, 239 * TC + 1, 240 * TC + 4);
    t0 = cyc;
    wait_pulse(1'b1);
    chk_rng("release gap", cyc - t0, 199 * TC + 1, 200 * TC + 4);
    idle(300);
    chk_g(8'h0c);
  endtask
  task automatic t_gate;
    set_level(8'hba);
    idle(100);
    wr(agcgs_pkg::OFF_MAXG, 16'h0002);
    idle(1000);
    chk_g(8'h0c);
    rd(agcgs_pkg::OFF_STATUS, 16'h050c, "gated status");
    set_level(8'hec);
    idle(2400);
    chk_g(8'h04);
    wr(agcgs_pkg::OFF_MAXG, 16'h001e);
  endtask
  task automatic t_shut;
    logic [15:0] tab [4][3] = '{'{16'h000f, 16'h0001, 16'h0004}, '{16'h0017, 16'h0002, 16'h000c},
      '{16'h001f, 16'h0000, 16'h000c}, '{16'h0007, 16'h0003, 16'h000c}};
    foreach (tab[i])
    begin
      wr(agcgs_pkg::OFF_CTRL, tab[i][0]);
      idle(4);
      chk("on", {14'h0000, left_on, right_on}, tab[i][1]);
      chk_g(tab[i][2][7:0]);
    end
  endtask
  task automatic t_fixed;
    logic [15:0] tab [6][3] = '{'{16'h0000, 16'h003b, 16'h0000}, '{16'h0020, 16'h003b, 16'h00f6},
      '{16'h0020, 16'h0022, 16'h00c8}, '{16'h0060, 16'h001f, 16'h003c},
      '{16'h0000, 16'h001f, 16'h003c}, '{16'h0040, 16'h0024, 16'h00c8}};
    foreach (tab[i])
    begin
      wr(agcgs_pkg::OFF_CTRL, tab[i][0]);
      wr(agcgs_pkg::OFF_FIXED, tab[i][1]);
      idle(4);
      chk_g(tab[i][2][7:0]);
    end
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      error_cnt++;
      test_done();
    end
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_track();
    t_gate();
    t_shut();
    t_fixed();
    test_done();
  end
endmodule // tb_top
